// ### rtl/amc_mode_config.sv
`timescale 1ns/1ps
// ==========================================================
// mode configuration register, address 6
// decodes the stored byte for the analog and pin logic
module amc_mode_config (
  input  wire logic          mclk,           // 20 MHz clock
  input  wire logic          rst_n,          // async reset, active low
  input  wire logic          regWrite,       // one-cycle write strobe
  input  wire logic          regRead,        // read request, level
  input  wire logic [3:0]    regAddr,        // register address
  input  wire logic [7:0]    regWdata,       // write data
  output logic      [7:0]    regRdata,       // registered read data
  input  wire logic          startCmd,       // software start pulse
  input  wire logic          stopCmd,        // software stop pulse
  output amc_pkg::amc_cfg_t  cfg,            // decoded fields
  output logic               converting,     // conversions running
  output amc_pkg::amc_pwr_t  pwrState        // power state
);
  import amc_pkg::*;

  // ==========================================================
  // storage
  // the register itself plus the flags that follow from it
  logic [7:0] modeCfg_reg;    // stored register value
  logic [7:0] regRdata_reg;   // read data flop
  logic       running_reg;    // conversion run flag

  // address decode shared by read and write
  // one compare, so read and write never disagree on the map
  function automatic logic hitMode(input logic [3:0] a);
    hitMode = (a == MODE_CFG_ADDR);  // RL1
  endfunction

  // register write; reserved bit masked so it never stores
  // other addresses and idle cycles leave the byte untouched
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      modeCfg_reg <= MODE_CFG_RESET;  // RL1
    end else if (regWrite && hitMode(regAddr)) begin
      modeCfg_reg <= regWdata & MODE_CFG_WMASK;  // RL12
    end
  end

  // read path; unmapped addresses read as zero
  // the flop holds between reads, so the host may sample late
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata_reg <= MODE_CFG_RESET;
    end else if (regRead) begin
      regRdata_reg <= hitMode(regAddr) ? modeCfg_reg : 8'h00;  // RL12
    end
  end
  // read data leaves from a flop as the bus expects
  assign regRdata = regRdata_reg;

  // ==========================================================
  // field decode
  // pure wiring of stored bits; the flops stay the only state
  // reserved trigger code passes through; the host keeps it out
  always_comb begin
    cfg.extendedRange = modeCfg_reg[RANGE_BIT];                 // RL2
    cfg.dataoutReady  = modeCfg_reg[SDO_BIT];                   // RL3
    cfg.trigMode      = amc_trig_t'(modeCfg_reg[TRIG_HI:TRIG_LO]);  // RL5
    cfg.lowSpeed      = modeCfg_reg[SPEED_BIT];                 // RL6
    cfg.autoStandby   = modeCfg_reg[STBY_BIT];                  // RL7 RL8
    cfg.fullPowerDown = modeCfg_reg[FULL_POWER_DOWN_BIT];                  // RL9 RL10
  end

  // run flag; start and stop together do nothing, and a stop is
  // dropped in synchronized mode since the pin owns timing there
  // power down wins over any command in the same cycle
  // start and stop are single-cycle strobes from the command decoder
  // limitation: this flag tracks run state only, not conversion timing
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      running_reg <= 1'b0;
    end else if (cfg.fullPowerDown) begin
      running_reg <= 1'b0;  // RL9
    end else if (startCmd && !stopCmd) begin
      running_reg <= 1'b1;
    end else if (stopCmd && !startCmd && cfg.trigMode != TRIG_SYNC) begin
      running_reg <= 1'b0;  // RL11
    end
  end
  // converting leaves a flop, so it never glitches
  assign converting = running_reg;

  // ==========================================================
  // power state
  // tracker sees only the run flag and the two power bits
  amc_power_ctrl uPower (
    .mclk          (mclk),
    .rst_n         (rst_n),
    .converting    (running_reg),
    .autoStandby   (cfg.autoStandby),
    .fullPowerDown (cfg.fullPowerDown),
    .pwrState      (pwrState)
  );

  // ==========================================================
  // checks; every property samples on mclk and sleeps through reset

  // ==========================================================
  // storage checks

  // the reserved bit can never hold a one
  AST_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)  // RL12
    (modeCfg_reg & ~MODE_CFG_WMASK) == '0)
    else $error("reserved bit set");

  // an accepted write stores the masked byte on the next edge
  AST_WRITE_STORES: assert property (@(posedge mclk) disable iff (!rst_n)  // RL1
    (regWrite && hitMode(regAddr))
      |=> modeCfg_reg == ($past(regWdata) & MODE_CFG_WMASK))
    else $error("write not stored");

  // without a write to this address the stored byte never moves
  AST_NO_STRAY_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)  // RL1
    !(regWrite && hitMode(regAddr)) |=> $stable(modeCfg_reg))
    else $error("register changed without a write");

  // ==========================================================
  // read path checks

  // a read of this address returns the byte held when it was taken
  AST_READBACK: assert property (@(posedge mclk) disable iff (!rst_n)  // RL12
    (regRead && hitMode(regAddr)) |=> regRdata == $past(modeCfg_reg))
    else $error("readback mismatch");

  // any other address reads as zero
  AST_UNMAPPED_READ: assert property (@(posedge mclk) disable iff (!rst_n)  // RL1
    (regRead && !hitMode(regAddr)) |=> regRdata == '0)
    else $error("unmapped read not zero");

  // read data stands until the next read request
  AST_RDATA_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)  // RL1
    !regRead |=> $stable(regRdata))
    else $error("read data moved without a read");

  // ==========================================================
  // field decode checks; each field follows its written bit

  // range and data-out pin function
  AST_RANGE_SDO: assert property (@(posedge mclk) disable iff (!rst_n)  // RL2 RL3
    (regWrite && hitMode(regAddr))
      |=> cfg.extendedRange == $past(regWdata[RANGE_BIT])
        && cfg.dataoutReady == $past(regWdata[SDO_BIT]))
    else $error("range or data-out decode wrong");

  // trigger pin interpretation, reserved code included
  AST_TRIG_DECODE: assert property (@(posedge mclk) disable iff (!rst_n)  // RL5
    (regWrite && hitMode(regAddr))
      |=> cfg.trigMode == amc_trig_t'($past(regWdata[TRIG_HI:TRIG_LO])))
    else $error("trigger decode wrong");

  // speed mode select
  AST_SPEED: assert property (@(posedge mclk) disable iff (!rst_n)  // RL6
    (regWrite && hitMode(regAddr)) |=> cfg.lowSpeed == $past(regWdata[SPEED_BIT]))
    else $error("speed decode wrong");

  // standby select
  AST_STBY_DECODE: assert property (@(posedge mclk) disable iff (!rst_n)  // RL7 RL8
    (regWrite && hitMode(regAddr)) |=> cfg.autoStandby == $past(regWdata[STBY_BIT]))
    else $error("standby decode wrong");

  // power down select
  AST_FULL_POWER_DOWN_DECODE: assert property (@(posedge mclk) disable iff (!rst_n)  // RL9 RL10
    (regWrite && hitMode(regAddr)) |=> cfg.fullPowerDown == $past(regWdata[FULL_POWER_DOWN_BIT]))
    else $error("power down decode wrong");

  // ==========================================================
  // run flag checks

  // power down forces the run flag low on the next edge
  AST_FULL_POWER_DOWN_HALTS: assert property (@(posedge mclk) disable iff (!rst_n)  // RL9
    cfg.fullPowerDown |=> !running_reg)
    else $error("converting while powered down");

  // a lone start runs the converter when powered
  AST_START: assert property (@(posedge mclk) disable iff (!rst_n)  // RL10
    (startCmd && !stopCmd && !cfg.fullPowerDown) |=> running_reg)
    else $error("start ignored");

  // start and stop together leave the run flag alone
  AST_BOTH_CMDS: assert property (@(posedge mclk) disable iff (!rst_n)  // RL10
    (startCmd && stopCmd && !cfg.fullPowerDown) |=> running_reg == $past(running_reg))
    else $error("start plus stop changed run flag");

  // stop is dropped in synchronized mode
  AST_SYNC_STOP: assert property (@(posedge mclk) disable iff (!rst_n)  // RL11
    (running_reg && stopCmd && cfg.trigMode == TRIG_SYNC && !cfg.fullPowerDown)
      |=> running_reg)
    else $error("stop honoured in sync mode");

  // stop is honoured in every other mode
  AST_STOP: assert property (@(posedge mclk) disable iff (!rst_n)  // RL11
    (stopCmd && !startCmd && cfg.trigMode != TRIG_SYNC) |=> !running_reg)
    else $error("stop ignored");

  // the flag never rises without a start
  AST_NO_SELF_START: assert property (@(posedge mclk) disable iff (!rst_n)  // RL10
    (!running_reg && !startCmd) |=> !running_reg)
    else $error("run flag rose without start");

  // ==========================================================
  // scenario covers

  // a write lands on the mode register
  COV_WRITE: cover property (@(posedge mclk) disable iff (!rst_n)
    regWrite && hitMode(regAddr));

  // a stop arrives while synchronized and running
  COV_SYNC_STOP: cover property (@(posedge mclk) disable iff (!rst_n)
    running_reg && stopCmd && cfg.trigMode == TRIG_SYNC);

  // power down catches the converter running
  COV_FULL_POWER_DOWN: cover property (@(posedge mclk) disable iff (!rst_n)
    cfg.fullPowerDown && running_reg);

  // start and stop strobe together
  COV_BOTH_CMDS: cover property (@(posedge mclk) disable iff (!rst_n)
    startCmd && stopCmd);
endmodule

// ### rtl/amc_pkg.sv
// Behaviour
// [RL1] mode register at address 6, resets to zero
// [RL2] bit 7 widens input range by quarter
// [RL3] bit 5 selects data-only or data-plus-ready
// [RL4] host uses data-only mode in daisy chains
// [RL5] bits 4:3 trigger mode; 11 reserved
// [RL6] bit 2 selects high or low speed
// [RL7] bit 1 clear: idle, fully powered
// [RL8] bit 1 set: auto standby, auto wake
// [RL9] bit 0 powers down all but interface
// [RL10] bit 0 clear restores normal operation
// [RL11] synchronized mode ignores software stop command
// [RL12] reserved bit 6 reads zero, writes ignored
package amc_pkg;
  // ==========================================================
  // register map
  localparam logic [3:0] MODE_CFG_ADDR  = 4'h6;
  localparam logic [7:0] MODE_CFG_RESET = 8'h00;
  localparam logic [7:0] MODE_CFG_WMASK = 8'hbf;  // bit 6 reserved
  localparam int         RANGE_BIT      = 7;
  localparam int         SDO_BIT        = 5;
  localparam int         TRIG_HI        = 4;
  localparam int         TRIG_LO        = 3;
  localparam int         SPEED_BIT      = 2;
  localparam int         STBY_BIT       = 1;
  localparam int         FULL_POWER_DOWN_BIT       = 0;

  // ==========================================================
  // trigger pin interpretation
  typedef enum logic [1:0] {
    TRIG_START_STOP = 2'h0,
    TRIG_ONE_SHOT   = 2'h1,
    TRIG_SYNC       = 2'h2,
    TRIG_RESERVED   = 2'h3
  } amc_trig_t;

  // decoded configuration carried to the rest of the converter
  typedef struct packed {
    logic      extendedRange;   // 25 % wider input span
    logic      dataoutReady;    // dual function data-out pin
    amc_trig_t trigMode;        // trigger pin interpretation
    logic      lowSpeed;        // 3.2 MHz instead of 25.6 MHz
    logic      autoStandby;     // power down when stopped
    logic      fullPowerDown;   // everything but interface off
  } amc_cfg_t;

  // power state reported to analog control
  typedef enum logic [1:0] {
    PWR_ACTIVE  = 2'h0,
    PWR_IDLE    = 2'h1,
    PWR_STANDBY = 2'h2,
    PWR_DOWN    = 2'h3
  } amc_pwr_t;
endpackage

// ### rtl/amc_power_ctrl.sv
`timescale 1ns/1ps
// ==========================================================
// power state tracker
module amc_power_ctrl (
  input  wire logic          mclk,           // 20 MHz clock
  input  wire logic          rst_n,          // async reset, active low
  input  wire logic          converting,     // conversions running
  input  wire logic          autoStandby,    // standby select
  input  wire logic          fullPowerDown,  // power down bit
  output amc_pkg::amc_pwr_t  pwrState        // registered state
);
  import amc_pkg::*;

  amc_pwr_t pwrState_reg;   // current state
  amc_pwr_t pwrState_next;  // next state

  // state choice by priority: power-down beats everything
  always_comb begin
    case (1'b1)
      fullPowerDown: pwrState_next = PWR_DOWN;     // RL9
      converting:    pwrState_next = PWR_ACTIVE;   // RL10 RL8
      autoStandby:   pwrState_next = PWR_STANDBY;  // RL8
      default:       pwrState_next = PWR_IDLE;     // RL7
    endcase
  end

  // state register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pwrState_reg <= PWR_IDLE;  // what a cleared register asks for
    end else begin
      pwrState_reg <= pwrState_next;
    end
  end

  assign pwrState = pwrState_reg;

  AST_FULL_POWER_DOWN_WINS: assert property (@(posedge mclk) disable iff (!rst_n)  // RL9
    fullPowerDown |=> pwrState == PWR_DOWN)
    else $error("power down not entered");
  AST_IDLE_POWERED: assert property (@(posedge mclk) disable iff (!rst_n)  // RL7
    (!fullPowerDown && !converting && !autoStandby) |=> pwrState == PWR_IDLE)
    else $error("idle state not entered");
  AST_STANDBY: assert property (@(posedge mclk) disable iff (!rst_n)  // RL8
    (!fullPowerDown && !converting && autoStandby) |=> pwrState == PWR_STANDBY)
    else $error("standby not entered");
  AST_WAKE: assert property (@(posedge mclk) disable iff (!rst_n)  // RL10
    (!fullPowerDown && converting) |=> pwrState == PWR_ACTIVE)
    else $error("did not resume active");
  COV_STANDBY_WAKE: cover property (@(posedge mclk) disable iff (!rst_n)
    pwrState == PWR_STANDBY ##1 pwrState == PWR_ACTIVE);
endmodule

// ### verification/amc_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// host controller model, one byte per access
module amc_host_model #(
  parameter bit CHAINED = 1'b0       // several converters on one chain
) (
  input  wire logic       mclk,      // 20 MHz clock
  output logic            regWrite,  // write strobe
  output logic            regRead,   // read request
  output logic      [3:0] regAddr,   // register address
  output logic      [7:0] regWdata,  // write data
  input  wire logic [7:0] regRdata   // read data
);
  // idle bus at time zero
  initial begin
    regWrite = 1'b0;
    regRead  = 1'b0;
    regAddr  = 4'h0;
    regWdata = 8'h00;
  end

  // the host never sends the reserved trigger code, and keeps the
  // data-out pin to data only when converters share a chain
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] w;
    w = d;
    if (a == amc_pkg::MODE_CFG_ADDR && CHAINED) begin
      w[amc_pkg::SDO_BIT] = 1'b0;
    end
    if (a == amc_pkg::MODE_CFG_ADDR && w[amc_pkg::TRIG_HI:amc_pkg::TRIG_LO] == 2'h3) begin
      w[amc_pkg::TRIG_LO] = 1'b0;
    end
    @(posedge mclk);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= w;
    @(posedge mclk);
    regWrite <= 1'b0;
    regWdata <= ~w;  // released data shows no stale byte
  endtask

  // read data is sampled once the taking edge has landed
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask
endmodule

// ### verification/amc_mode_config_tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// bench for the mode configuration register
module amc_mode_config_tb_top;
  import amc_pkg::*;
  logic       mclk = 1'b0;    // clock
  logic       rst_n = 1'b0;   // reset, low active
  logic       startCmd = 1'b0; // start pulse
  logic       stopCmd = 1'b0;  // stop pulse
  logic       regWrite, regRead, converting;
  logic [3:0] regAddr;
  logic [7:0] regWdata, regRdata, rv;
  amc_cfg_t   cfg;
  amc_pwr_t   pwrState;
  int         miscompares = 0; // mismatch count
  int         checked = 0;     // comparison count
  int         cycles = 0;      // timeout counter

  always #25 mclk = ~mclk;

  amc_host_model host (.mclk(mclk), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));
  amc_mode_config uut (.mclk(mclk), .rst_n(rst_n), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .startCmd(startCmd), .stopCmd(stopCmd), .cfg(cfg), .converting(converting),
    .pwrState(pwrState));

  // ==========================================================
  // reporting
  task automatic end_of_test();
    if (miscompares == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // a hang counts as a mismatch
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      end_of_test();
    end
  end

  // one start or stop pulse, then let run flag and power state settle
  task automatic pulse(input bit stop);
    @(posedge mclk);
    if (stop) stopCmd <= 1'b1;
    else startCmd <= 1'b1;
    @(posedge mclk);
    startCmd <= 1'b0;
    stopCmd  <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_fields();
    host.wr(4'h6, 8'hff);
    @(posedge mclk);
    #1;
    chk(8'(cfg.extendedRange), 8'h01);
    chk(8'(cfg.dataoutReady), 8'h01);
    chk(8'(cfg.lowSpeed), 8'h01);
    chk(8'(pwrState), 8'(PWR_DOWN));
    chk(8'(cfg.trigMode), 8'(TRIG_SYNC));
    host.rd(4'h6, rv);
    chk(rv, 8'hb7);
    pulse(1'b0);
    chk(8'(converting), 8'h00);
    host.wr(4'h6, 8'h00);
    @(posedge mclk);
    #1;
    chk(8'(pwrState), 8'(PWR_IDLE));
  endtask

  task automatic t_trig_unmapped();
    for (int i = 0; i < 3; i++) begin
      host.wr(4'h6, 8'(i << 3));
      host.rd(4'h6, rv);
      chk(rv, 8'(i << 3));
      chk(8'(cfg.trigMode), 8'(i));
    end
    host.wr(4'h7, 8'hff);
    host.rd(4'h7, rv);
    chk(rv, 8'h00);
    host.rd(4'h6, rv);
    chk(rv, 8'h10);
  endtask

  task automatic t_run(input logic [7:0] mode, input logic [7:0] runAfter,
                       input logic [7:0] pwrAfter);
    host.wr(4'h6, mode);
    pulse(1'b0);
    chk(8'(converting), 8'h01);
    chk(8'(pwrState), 8'(PWR_ACTIVE));
    pulse(1'b1);
    chk(8'(converting), runAfter);
    chk(8'(pwrState), pwrAfter);
  endtask

  // reset in mid-run: register, run flag and read data all clear
  task automatic t_reset();
    host.wr(4'h6, 8'ha6);
    pulse(1'b0);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk(8'(cfg), 8'h00);
    chk(8'(converting), 8'h00);
    chk(regRdata, 8'h00);
    @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    chk(8'(pwrState), 8'(PWR_IDLE));
    host.rd(4'h6, rv);
    chk(rv, 8'h00);
  endtask

  // start and stop in one cycle change nothing, idle or running
  task automatic t_both();
    host.wr(4'h6, 8'h00);
    for (int r = 0; r < 2; r++) begin
      if (r == 1) pulse(1'b0);
      @(posedge mclk);
      startCmd <= 1'b1;
      stopCmd  <= 1'b1;
      @(posedge mclk);
      startCmd <= 1'b0;
      stopCmd  <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      chk(8'(converting), 8'(r));
      chk(8'(pwrState), (r == 1) ? 8'(PWR_ACTIVE) : 8'(PWR_IDLE));
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    chk(8'(cfg), 8'h00);
    chk(8'(pwrState), 8'(PWR_IDLE));
    host.rd(4'h6, rv);
    chk(rv, 8'h00);
    t_fields();
    t_trig_unmapped();
    t_run(8'h02, 8'h00, 8'(PWR_STANDBY));
    t_run(8'h00, 8'h00, 8'(PWR_IDLE));
    t_run(8'h10, 8'h01, 8'(PWR_ACTIVE));
    t_reset();
    t_both();
    end_of_test();
  end
endmodule
